/* File: logic/rbc_pkg.sv */
package rbc_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_ZERO_SEL   = 4'h0;
  localparam logic [3:0] ADDR_ONE_SEL    = 4'h1;
  localparam logic [3:0] ADDR_THIRD_SEL  = 4'h2;
  localparam logic [3:0] ADDR_FIRST_IRQ  = 4'h3;
  localparam logic [3:0] ADDR_SECOND_IRQ = 4'h4;
  localparam logic [3:0] ADDR_CLK_MODE   = 4'h5;
  localparam logic [3:0] ADDR_STATUS     = 4'h6;
  localparam logic [3:0] ADDR_CAUSE      = 4'h7;
  localparam logic [3:0] ADDR_PTR_BANK   = 4'h8;
  localparam logic [3:0] ADDR_AUX        = 4'h9;
  localparam logic [3:0] ADDR_PTR_ROW    = 4'ha;
  localparam logic [3:0] ADDR_PTR_DIGIT  = 4'hb;
  localparam logic [3:0] ADDR_TEMP       = 4'hc;
  localparam logic [3:0] ADDR_PTR_OK     = 4'hd;

  // Field positions
  localparam int CLK_SYS_MAIN  = 0;
  localparam int CLK_MAIN_STOP = 1;
  localparam int CLK_RING_STOP = 2;
  localparam int SEL_FIRST_IRQ  = 0;
  localparam int SEL_SECOND_IRQ = 2;
  localparam int IRQ_POLARITY   = 2;
  localparam int IRQ_INPUT_EN   = 3;

  // Widths of the scratch pointer registers and their count
  localparam int PTR_BANK_W  = 2;
  localparam int AUX_W       = 3;
  localparam int PTR_ROW_W   = 4;
  localparam int PTR_DIGIT_W = 4;
  localparam int TEMP_W      = 8;
  localparam int PTR_CNT     = 5;

  // Instruction codes seen on the instruction port
  localparam logic [3:0] OP_NOP       = 4'h0;
  localparam logic [3:0] OP_IRQ_OFF   = 4'h1;
  localparam logic [3:0] OP_ARM       = 4'h2;
  localparam logic [3:0] OP_PWR_DOWN  = 4'h3;
  localparam logic [3:0] OP_WDT_STOP  = 4'h4;
  localparam logic [3:0] OP_WDT_RST   = 4'h5;
  localparam logic [3:0] OP_SEL_CER   = 4'h6;
  localparam logic [3:0] OP_SEL_RC    = 4'h7;
  localparam logic [3:0] OP_SEL_XTAL  = 4'h8;

  // Recorded main oscillator type
  localparam logic [1:0] OSC_NONE = 2'h0;
  localparam logic [1:0] OSC_CER  = 2'h1;
  localparam logic [1:0] OSC_RC   = 2'h2;
  localparam logic [1:0] OSC_XTAL = 2'h3;

  // Reset values
  localparam logic [2:0] CLK_MODE_RESET = 3'h2;

  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_ARMED  = 4'h2,
    ST_BACKUP = 4'h4,
    ST_WAKE   = 4'h8
  } rbc_state_type;

endpackage : rbc_pkg

/* File: logic/rbc_wake_detect.sv */
`timescale 1ns/1ps
module rbc_wake_detect #(
  parameter int PORT_W = 4
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic [PORT_W-1:0] port_zero_i,
  input  wire logic [PORT_W-1:0] port_one_i,
  input  wire logic              first_ext_irq_pin_i,
  input  wire logic              second_ext_irq_pin_i,
  input  wire logic [PORT_W-1:0] zero_sel_i,
  input  wire logic [PORT_W-1:0] one_sel_i,
  input  wire logic [3:0]        third_sel_i,
  input  wire logic [3:0]        first_ctrl_i,
  input  wire logic [3:0]        second_ctrl_i,
  output logic                   wake_o,
  output logic [3:0]             cause_o
);

  typedef struct packed {
    logic       wake;
    logic [3:0] cause;
  } rbc_det_type;

  rbc_det_type q;
  rbc_det_type d;

  // A selected key line held low is a pressed key
  function automatic logic any_low(input logic [PORT_W-1:0] sel,
                                   input logic [PORT_W-1:0] pins);
    any_low = |(sel & ~pins);
  endfunction : any_low

  // Return conditions of all enabled sources
  always_comb begin
    d.cause[0] = any_low(zero_sel_i, port_zero_i);
    d.cause[1] = any_low(one_sel_i, port_one_i);
    d.cause[2] = third_sel_i[rbc_pkg::SEL_FIRST_IRQ] &&
      (first_ext_irq_pin_i == first_ctrl_i[rbc_pkg::IRQ_POLARITY]);
    d.cause[3] = third_sel_i[rbc_pkg::SEL_SECOND_IRQ] &&
      (second_ext_irq_pin_i == second_ctrl_i[rbc_pkg::IRQ_POLARITY]);
    d.wake = |d.cause;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wake_o  = q.wake;
  assign cause_o = q.cause;

endmodule : rbc_wake_detect

/* File: logic/rbc_backup_clock.sv */
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// R01: Bank, auxiliary and temporary registers count as unset after reset.
// R02: Back-up entered only by power-down right after the arming instruction.
// R03: Software disables interrupts before arming and power-down.
// R04: Enabled key-on sources wake; a condition already true returns at once.
// R05: Software checks no return condition holds before power-down.
// R06: All five pointer registers count as unset after a return.
// R07: Watchdog is active again after every return from back-up.
// R08: Software clears the first watchdog flag with restart before back-up.
// R09: Software clears third select bit 0 when first irq input is off.
// R10: Software clears third select bit 2 when second irq input is off.
// R11: Only the first clock-select instruction is recorded.
// R12: Clock select records the type; no start, no clock switch.
// R13: Without a clock select the main clock stays unusable.
// R14: Stopped sources refused as system clock; active source cannot stop.
// R15: Software selects the clock first thing in its setup routine.
// R16: External clock: ceramic select, then clear the main stop bit.
// R17: Main clock input forced high while the main stop bit is set.
module rbc_backup_clock #(
  parameter int PORT_W = 4,
  parameter int WDT_W  = 16
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              instr_valid_i,
  input  wire logic [3:0]        instr_code_i,
  input  wire logic [PORT_W-1:0] port_zero_i,
  input  wire logic [PORT_W-1:0] port_one_i,
  input  wire logic              first_ext_irq_pin_i,
  input  wire logic              second_ext_irq_pin_i,
  output logic                   backup_o,
  output logic                   wake_o,
  output logic                   main_osc_en_o,
  output logic                   sys_clk_main_o,
  output logic                   xin_force_high_o,
  output logic                   wdt_active_o,
  output logic                   wdt_flag_o
);

  typedef struct packed {
    rbc_pkg::rbc_state_type           st;
    logic [PORT_W-1:0]                zero_sel;
    logic [PORT_W-1:0]                one_sel;
    logic [3:0]                       third_sel;
    logic [3:0]                       first_ctrl;
    logic [3:0]                       second_ctrl;
    logic                             sys_main;
    logic                             main_stop;
    logic                             ring_stop;
    logic                             osc_en;
    logic                             sel_done;
    logic [1:0]                       osc;
    logic                             wdt_act;
    logic                             wdt_pend;
    logic                             watchdog_first_flag;
    logic [WDT_W-1:0]                 wdt_cnt;
    logic [rbc_pkg::PTR_BANK_W-1:0]   bank;
    logic [rbc_pkg::AUX_W-1:0]        aux;
    logic [rbc_pkg::PTR_ROW_W-1:0]    row;
    logic [rbc_pkg::PTR_DIGIT_W-1:0]  digit;
    logic [rbc_pkg::TEMP_W-1:0]       temp;
    logic [rbc_pkg::PTR_CNT-1:0]      ptr_ok;
    logic [3:0]                       cause;
    logic                             backup;
    logic                             wake;
    logic [7:0]                       rdata;
  } rbc_regs_type;

  rbc_regs_type q;
  rbc_regs_type d;
  logic         det_wake;
  logic [3:0]   det_cause;
  logic         op_arm;
  logic         op_pdn;
  logic         op_wstop;
  logic         op_watchdog_restart_instr;
  logic         op_sel;
  logic [1:0]   sel_type;
  logic         req_main;
  logic         req_stop;
  logic         clk_wr;

  // True when the given instruction is presented
  function automatic logic is_op(input logic       v,
                                 input logic [3:0] c,
                                 input logic [3:0] op);
    is_op = v && (c == op);
  endfunction : is_op

  // Return condition watcher for the key-on sources
  rbc_wake_detect #(
    .PORT_W (PORT_W)
  ) u_wake (
    .core_clk_i           (core_clk_i),
    .reset_i              (reset_i),
    .port_zero_i          (port_zero_i),
    .port_one_i           (port_one_i),
    .first_ext_irq_pin_i  (first_ext_irq_pin_i),
    .second_ext_irq_pin_i (second_ext_irq_pin_i),
    .zero_sel_i           (q.zero_sel),
    .one_sel_i            (q.one_sel),
    .third_sel_i          (q.third_sel),
    .first_ctrl_i         (q.first_ctrl),
    .second_ctrl_i        (q.second_ctrl),
    .wake_o               (det_wake),
    .cause_o              (det_cause)
  );

  // Instruction decode, also active while the core is stopped
  always_comb begin
    op_arm   = is_op(instr_valid_i, instr_code_i, rbc_pkg::OP_ARM);
    op_pdn   = is_op(instr_valid_i, instr_code_i, rbc_pkg::OP_PWR_DOWN);
    op_wstop = is_op(instr_valid_i, instr_code_i, rbc_pkg::OP_WDT_STOP);
    op_watchdog_restart_instr  = is_op(instr_valid_i, instr_code_i, rbc_pkg::OP_WDT_RST);
    op_sel   = 1'b1;
    sel_type = rbc_pkg::OSC_NONE;
    if (is_op(instr_valid_i, instr_code_i, rbc_pkg::OP_SEL_CER)) begin
      sel_type = rbc_pkg::OSC_CER;
    end else if (is_op(instr_valid_i, instr_code_i,
                       rbc_pkg::OP_SEL_RC)) begin
      sel_type = rbc_pkg::OSC_RC;
    end else if (is_op(instr_valid_i, instr_code_i,
                       rbc_pkg::OP_SEL_XTAL)) begin
      sel_type = rbc_pkg::OSC_XTAL;
    end else begin
      op_sel = 1'b0;
    end
  end

  // Next state of the whole block
  always_comb begin
    d        = q;
    d.rdata  = 8'h00;
    d.wake   = 1'b0;
    clk_wr   = reg_wr_i && (reg_addr_i == rbc_pkg::ADDR_CLK_MODE);
    req_main = reg_wdata_i[rbc_pkg::CLK_SYS_MAIN];
    req_stop = reg_wdata_i[rbc_pkg::CLK_MAIN_STOP] || !q.sel_done;
    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        rbc_pkg::ADDR_ZERO_SEL:   d.zero_sel = reg_wdata_i[PORT_W-1:0];
        rbc_pkg::ADDR_ONE_SEL:    d.one_sel = reg_wdata_i[PORT_W-1:0];
        rbc_pkg::ADDR_THIRD_SEL:  d.third_sel = reg_wdata_i[3:0];
        rbc_pkg::ADDR_FIRST_IRQ:  d.first_ctrl = reg_wdata_i[3:0];
        rbc_pkg::ADDR_SECOND_IRQ: d.second_ctrl = reg_wdata_i[3:0];
        rbc_pkg::ADDR_PTR_BANK: begin
          d.bank      = reg_wdata_i[rbc_pkg::PTR_BANK_W-1:0];
          d.ptr_ok[0] = 1'b1;
        end
        rbc_pkg::ADDR_AUX: begin
          d.aux       = reg_wdata_i[rbc_pkg::AUX_W-1:0];
          d.ptr_ok[1] = 1'b1;
        end
        rbc_pkg::ADDR_PTR_ROW: begin
          d.row       = reg_wdata_i[rbc_pkg::PTR_ROW_W-1:0];
          d.ptr_ok[2] = 1'b1;
        end
        rbc_pkg::ADDR_PTR_DIGIT: begin
          d.digit     = reg_wdata_i[rbc_pkg::PTR_DIGIT_W-1:0];
          d.ptr_ok[3] = 1'b1;
        end
        rbc_pkg::ADDR_TEMP: begin
          d.temp      = reg_wdata_i[rbc_pkg::TEMP_W-1:0];
          d.ptr_ok[4] = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Clock mode write with refusal of unsafe changes
    if (clk_wr) begin
      if (req_main ? !q.main_stop : !q.ring_stop) begin // see R14
        d.sys_main = req_main;
      end
      d.main_stop = req_stop && !d.sys_main; // see R13 see R14
      d.ring_stop = reg_wdata_i[rbc_pkg::CLK_RING_STOP] && d.sys_main;
    end
    d.osc_en = !d.main_stop;
    // First clock select wins and only records the type
    if (op_sel && !q.sel_done && q.st == rbc_pkg::ST_RUN) begin
      d.sel_done = 1'b1; // see R11 see R12
      d.osc      = sel_type;
    end
    // Watchdog stop must be followed at once by restart
    if (instr_valid_i && q.st != rbc_pkg::ST_BACKUP) begin
      d.wdt_pend = op_wstop;
      if (op_watchdog_restart_instr && q.wdt_pend) begin
        d.wdt_act = 1'b0; // see R07
      end
    end
    // Restart clears the count and the first flag; overflow wins
    if (op_watchdog_restart_instr) begin
      d.wdt_cnt = '0;
      d.watchdog_first_flag    = 1'b0; // see R08
    end else if (q.wdt_act && q.st != rbc_pkg::ST_BACKUP) begin
      d.wdt_cnt = q.wdt_cnt + 1'b1;
    end
    if (q.wdt_act && q.st != rbc_pkg::ST_BACKUP && (&q.wdt_cnt)) begin
      d.watchdog_first_flag = 1'b1;
    end
    // Back-up sequencer
    case (q.st)
      rbc_pkg::ST_RUN: begin
        if (op_arm) begin
          d.st = rbc_pkg::ST_ARMED; // see R02
        end
      end
      rbc_pkg::ST_ARMED: begin
        if (instr_valid_i) begin
          if (!op_pdn) begin
            d.st = rbc_pkg::ST_RUN;
          end else if (det_wake) begin
            d.st = rbc_pkg::ST_WAKE; // see R04
          end else begin
            d.st = rbc_pkg::ST_BACKUP; // see R02
          end
        end
      end
      rbc_pkg::ST_BACKUP: begin
        if (det_wake) begin
          d.st = rbc_pkg::ST_WAKE; // see R04 see R09 see R10
        end
      end
      rbc_pkg::ST_WAKE: begin
        d.st = rbc_pkg::ST_RUN;
      end
      default: begin
        d.st = rbc_pkg::ST_RUN;
      end
    endcase
    // Entry to the wake state reactivates the watchdog, drops pointers
    if (d.st == rbc_pkg::ST_WAKE && q.st != rbc_pkg::ST_WAKE) begin
      d.wake     = 1'b1;
      d.wdt_act  = 1'b1; // see R07
      d.wdt_pend = 1'b0;
      d.ptr_ok   = '0; // see R06
      d.cause    = det_cause;
    end
    d.backup = (d.st == rbc_pkg::ST_BACKUP);
    // Read data stands only in the cycle after the strobe
    if (reg_rd_i) begin
      case (reg_addr_i)
        rbc_pkg::ADDR_ZERO_SEL:   d.rdata = 8'(q.zero_sel);
        rbc_pkg::ADDR_ONE_SEL:    d.rdata = 8'(q.one_sel);
        rbc_pkg::ADDR_THIRD_SEL:  d.rdata = {4'h0, q.third_sel};
        rbc_pkg::ADDR_FIRST_IRQ:  d.rdata = {4'h0, q.first_ctrl};
        rbc_pkg::ADDR_SECOND_IRQ: d.rdata = {4'h0, q.second_ctrl};
        rbc_pkg::ADDR_CLK_MODE:
          d.rdata = {5'h00, q.ring_stop, q.main_stop, q.sys_main};
        rbc_pkg::ADDR_STATUS:
          d.rdata = {2'h0, q.watchdog_first_flag, q.wdt_act, q.osc, q.sel_done,
                     q.backup};
        rbc_pkg::ADDR_CAUSE:      d.rdata = {4'h0, q.cause};
        rbc_pkg::ADDR_PTR_BANK:   d.rdata = 8'(q.bank);
        rbc_pkg::ADDR_AUX:        d.rdata = 8'(q.aux);
        rbc_pkg::ADDR_PTR_ROW:    d.rdata = 8'(q.row);
        rbc_pkg::ADDR_PTR_DIGIT:  d.rdata = 8'(q.digit);
        rbc_pkg::ADDR_TEMP:       d.rdata = q.temp;
        rbc_pkg::ADDR_PTR_OK:     d.rdata = 8'(q.ptr_ok);
        default:                  d.rdata = 8'h00;
      endcase
    end
  end

  // State register; pointer contents count as unset until written
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q           <= '0;
      q.st        <= rbc_pkg::ST_RUN;
      q.sys_main  <= rbc_pkg::CLK_MODE_RESET[rbc_pkg::CLK_SYS_MAIN];
      q.main_stop <= rbc_pkg::CLK_MODE_RESET[rbc_pkg::CLK_MAIN_STOP];
      q.ring_stop <= rbc_pkg::CLK_MODE_RESET[rbc_pkg::CLK_RING_STOP];
      q.wdt_act   <= 1'b1;
      q.ptr_ok    <= '0; // see R01
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o      = q.rdata;
  assign backup_o         = q.backup;
  assign wake_o           = q.wake;
  assign main_osc_en_o    = q.osc_en;
  assign sys_clk_main_o   = q.sys_main;
  assign xin_force_high_o = q.main_stop; // see R17
  assign wdt_active_o     = q.wdt_act;
  assign wdt_flag_o       = q.watchdog_first_flag;

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_arm_pdn;
    (q.st == rbc_pkg::ST_RUN && op_arm) ##1 (op_pdn && !det_wake);
  endsequence

  sequence s_arm_wake;
    (q.st == rbc_pkg::ST_RUN && op_arm) ##1 (op_pdn && det_wake);
  endsequence

  chk_arm_pdn_entry: assert property ( // see R02
    s_arm_pdn |=> backup_o && !wake_o)
    else $error("arming then power-down did not enter back-up");

  chk_pdn_alone: assert property ( // see R02
    (q.st == rbc_pkg::ST_RUN && op_pdn) |=> !backup_o)
    else $error("power-down alone entered back-up");

  chk_wake_immediate: assert property ( // see R04
    s_arm_wake |=> wake_o && !backup_o ##1 q.st == rbc_pkg::ST_RUN)
    else $error("pending wake condition did not return at once");

  chk_wake_watchdog: assert property ( // see R07
    $rose(wake_o) |-> wdt_active_o && !backup_o)
    else $error("watchdog not active after return");

  chk_wake_pointers: assert property ( // see R06
    (backup_o && det_wake) |=> q.ptr_ok == '0 && wake_o)
    else $error("pointers still marked set after return");

  chk_osc_once: assert property ( // see R11
    $past(q.sel_done) |-> $stable(q.osc))
    else $error("oscillator type changed after first select");

  chk_sel_no_switch: assert property ( // see R12
    (op_sel && !clk_wr) |=> $stable(main_osc_en_o) &&
                           $stable(sys_clk_main_o))
    else $error("clock select changed oscillation or clock");

  chk_main_unused: assert property ( // see R13
    !q.sel_done |-> xin_force_high_o && !sys_clk_main_o)
    else $error("main clock usable without a clock select");

  chk_sysclk_runs: assert property ( // see R14
    (sys_clk_main_o |-> !xin_force_high_o) and
    (!sys_clk_main_o |-> !q.ring_stop))
    else $error("system clock source is stopped");

  chk_xin_release: assert property ( // see R17
    $fell(xin_force_high_o) |-> $past(clk_wr) && $past(q.sel_done) &&
                                main_osc_en_o)
    else $error("main input released without clearing stop bit");

endmodule : rbc_backup_clock

/* File: test/rbc_sw_model.sv */
`timescale 1ns/1ps
module rbc_sw_model #(
  parameter int PORT_W = 4
) (
  input  wire logic              core_clk_i,
  output logic                   instr_valid_o,
  output logic [3:0]             instr_code_o,
  output logic [PORT_W-1:0]      port_zero_o,
  output logic [PORT_W-1:0]      port_one_o,
  output logic                   first_irq_o,
  output logic                   second_irq_o
);
  // Idle: no instruction, key ports high, irq pins low
  initial begin
    instr_valid_o = 1'b0;
    instr_code_o  = rbc_pkg::OP_NOP;
    port_zero_o   = '1;
    port_one_o    = '1;
    first_irq_o   = 1'b0;
    second_irq_o  = 1'b0;
  end

  // One instruction, launched just after an edge
  task automatic exec(input logic [3:0] op);
    @(posedge core_clk_i);
    instr_valid_o <= 1'b1;
    instr_code_o  <= op;
    @(posedge core_clk_i);
    instr_valid_o <= 1'b0;
    instr_code_o  <= rbc_pkg::OP_NOP;
  endtask : exec

  // Entry: interrupts off, flag cleared, arm, then power-down at once
  task automatic enter_backup();
    exec(rbc_pkg::OP_IRQ_OFF);
    exec(rbc_pkg::OP_WDT_RST);
    // Arm and power-down on two adjacent edges, no idle slot between
    @(posedge core_clk_i);
    instr_valid_o <= 1'b1;
    instr_code_o  <= rbc_pkg::OP_ARM;
    @(posedge core_clk_i);
    instr_code_o  <= rbc_pkg::OP_PWR_DOWN;
    @(posedge core_clk_i);
    instr_valid_o <= 1'b0;
    instr_code_o  <= rbc_pkg::OP_NOP;
  endtask : enter_backup

  // Watchdog off as a consecutive pair
  task automatic wdt_off();
    exec(rbc_pkg::OP_WDT_STOP);
    exec(rbc_pkg::OP_WDT_RST);
  endtask : wdt_off

  // Port zero key pins and second irq pin, changed after an edge
  task automatic set_pins(input logic [PORT_W-1:0] p0, input logic irq2);
    @(posedge core_clk_i);
    port_zero_o  <= p0;
    second_irq_o <= irq2;
  endtask : set_pins
endmodule : rbc_sw_model

/* File: test/tb_ram_backup_clock_select.sv */
`timescale 1ns/1ps
module tb_ram_backup_clock_select;
  logic       core_clk_i;
  logic       reset_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic       instr_valid;
  logic [3:0] instr_code;
  logic [3:0] port_zero;
  logic [3:0] port_one;
  logic       irq_a;
  logic       irq_b;
  logic       backup_o;
  logic       wake_o;
  logic       main_osc_en_o;
  logic       sys_clk_main_o;
  logic       xin_force_high_o;
  logic       wdt_active_o;
  logic       wdt_flag_o;
  int         err_count;
  int         checks_done;
  int         cycles;
  logic [7:0] d;
  int         wake_cnt;
  int         backup_cnt;

  rbc_backup_clock #(.PORT_W(4), .WDT_W(4)) uut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .instr_valid_i(instr_valid),
    .instr_code_i(instr_code), .port_zero_i(port_zero),
    .port_one_i(port_one), .first_ext_irq_pin_i(irq_a),
    .second_ext_irq_pin_i(irq_b), .backup_o(backup_o), .wake_o(wake_o),
    .main_osc_en_o(main_osc_en_o), .sys_clk_main_o(sys_clk_main_o),
    .xin_force_high_o(xin_force_high_o), .wdt_active_o(wdt_active_o),
    .wdt_flag_o(wdt_flag_o));

  rbc_sw_model #(.PORT_W(4)) u_sw (
    .core_clk_i(core_clk_i), .instr_valid_o(instr_valid),
    .instr_code_o(instr_code), .port_zero_o(port_zero),
    .port_one_o(port_one), .first_irq_o(irq_a), .second_irq_o(irq_b));

  // Clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Hang guard
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  // Pulse watchers, read on the edge after the launching one
  always @(posedge core_clk_i) begin
    if (wake_o === 1'b1) wake_cnt <= wake_cnt + 1;
    if (backup_o === 1'b1) backup_cnt <= backup_cnt + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : reg_write

  // Read data stands in the cycle after the strobe only
  task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask : reg_read

  task automatic test_reset();
    check({7'h00, backup_o}, 8'h00, "backup after reset");
    check({7'h00, xin_force_high_o}, 8'h01, "xin forced");
    check({7'h00, main_osc_en_o}, 8'h00, "osc off");
    reg_read(rbc_pkg::ADDR_CLK_MODE, d);
    check(d, 8'h02, "clock mode reset");
    reg_read(rbc_pkg::ADDR_PTR_OK, d);
    check(d, 8'h00, "pointers unset");
    reg_read(4'he, d);
    check(d, 8'h00, "unmapped read");
  endtask : test_reset

  task automatic test_clock();
    reg_write(rbc_pkg::ADDR_CLK_MODE, 8'h01);
    reg_read(rbc_pkg::ADDR_CLK_MODE, d);
    check(d, 8'h02, "no select yet");
    u_sw.exec(rbc_pkg::OP_SEL_CER);
    u_sw.exec(rbc_pkg::OP_SEL_XTAL);
    reg_read(rbc_pkg::ADDR_STATUS, d);
    check({4'h0, d[3:0]}, 8'h06, "first select kept");
    check({7'h00, main_osc_en_o}, 8'h00, "select no start");
    check({7'h00, sys_clk_main_o}, 8'h00, "select no switch");
    reg_write(rbc_pkg::ADDR_CLK_MODE, 8'h03);
    reg_read(rbc_pkg::ADDR_CLK_MODE, d);
    check(d, 8'h02, "stopped source refused");
    reg_write(rbc_pkg::ADDR_CLK_MODE, 8'h00);
    reg_read(rbc_pkg::ADDR_CLK_MODE, d);
    check(d, 8'h00, "main started");
    check({7'h00, main_osc_en_o}, 8'h01, "osc on");
    check({7'h00, xin_force_high_o}, 8'h00, "xin released");
    reg_write(rbc_pkg::ADDR_CLK_MODE, 8'h05);
    reg_write(rbc_pkg::ADDR_CLK_MODE, 8'h07);
    reg_read(rbc_pkg::ADDR_CLK_MODE, d);
    check(d, 8'h05, "active source kept");
    check({7'h00, sys_clk_main_o}, 8'h01, "sys on main");
  endtask : test_clock

  task automatic test_backup();
    logic seen;
    seen = 1'b0;
    u_sw.exec(rbc_pkg::OP_PWR_DOWN);
    repeat (3) @(posedge core_clk_i);
    #1;
    check({7'h00, backup_o}, 8'h00, "lone power-down");
    reg_write(rbc_pkg::ADDR_ZERO_SEL, 8'h01);
    reg_write(rbc_pkg::ADDR_PTR_BANK, 8'h03);
    reg_read(rbc_pkg::ADDR_PTR_OK, d);
    check(d, 8'h01, "bank written");
    u_sw.wdt_off();
    reg_read(rbc_pkg::ADDR_STATUS, d);
    check({7'h00, wdt_active_o}, 8'h00, "watchdog stopped");
    check({7'h00, d[4]}, 8'h00, "status watchdog bit");
    // Key pins idle, so no return condition holds at power-down
    u_sw.enter_backup();
    repeat (2) @(posedge core_clk_i);
    #1;
    check({7'h00, backup_o}, 8'h01, "armed entry");
    check({7'h00, wdt_flag_o}, 8'h00, "flag clear at entry");
    u_sw.set_pins(4'he, 1'b0);
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge core_clk_i);
      #1;
      seen = (wake_o === 1'b1);
    end
    check({7'h00, seen}, 8'h01, "key-on wake");
    check({7'h00, backup_o}, 8'h00, "left backup");
    check({7'h00, wdt_active_o}, 8'h01, "watchdog back");
    u_sw.set_pins(4'hf, 1'b0);
    reg_read(rbc_pkg::ADDR_CAUSE, d);
    check(d, 8'h01, "wake cause port zero");
    reg_read(rbc_pkg::ADDR_PTR_OK, d);
    check(d, 8'h00, "pointers unset again");
  endtask : test_backup

  task automatic test_immediate();
    int w;
    int b;
    reg_write(rbc_pkg::ADDR_ZERO_SEL, 8'h00);
    reg_write(rbc_pkg::ADDR_SECOND_IRQ, 8'h0c);
    reg_write(rbc_pkg::ADDR_THIRD_SEL, 8'h04);
    u_sw.set_pins(4'hf, 1'b1);
    w = wake_cnt;
    b = backup_cnt;
    // Condition already true at power-down on purpose
    u_sw.enter_backup();
    repeat (4) @(posedge core_clk_i);
    #1;
    check(8'(wake_cnt - w), 8'h01, "immediate wake");
    check(8'(backup_cnt - b), 8'h00, "no backup held");
    reg_read(rbc_pkg::ADDR_CAUSE, d);
    check(d, 8'h08, "cause second irq");
    u_sw.set_pins(4'hf, 1'b0);
    reg_write(rbc_pkg::ADDR_THIRD_SEL, 8'h00);
    // Watchdog runs again after the return and overflows
    repeat (20) @(posedge core_clk_i);
    reg_read(rbc_pkg::ADDR_STATUS, d);
    check({7'h00, wdt_flag_o}, 8'h01, "watchdog flag set");
    check({7'h00, d[5]}, 8'h01, "status flag bit");
  endtask : test_immediate

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    err_count   = 0;
    checks_done = 0;
    cycles      = 0;
    wake_cnt    = 0;
    backup_cnt  = 0;
    reset_i     = 1'b1;
    reg_addr_i  = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    test_reset();
    test_clock();
    test_backup();
    test_immediate();
    summarize();
  end
endmodule : tb_ram_backup_clock_select
